// File: src/light_threshold_irq_flags.v
// light sensor control word flags, limit compare and interrupt pin, over AHB-Lite
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "light_irq_defines.vh"
module light_threshold_irq_flags (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // conversion engine
  input  wire        conv_done,
  input  wire [15:0] conv_result,
  input  wire        conv_ovf,
  output reg  [1:0]  conv_mode,
  // interrupt pin, open drain, and system interrupt
  output reg         int_pin_out,
  output reg         int_pin_oe,
  output reg         irq
);
  reg        rst_meta_reg;
  reg        rst_sync_reg;
  reg        ph_valid_reg;
  reg        ph_write_reg;
  reg  [7:0] ph_addr_reg;
  reg  [3:0] range_reg;
  reg        ctime_reg;
  reg  [1:0] mode_reg;
  reg        ovf_reg;
  reg        done_reg;
  reg        above_reg;
  reg        below_reg;
  reg        latch_reg;
  reg        pol_reg;
  reg        emask_reg;
  reg  [1:0] fc_reg;
  reg  [15:0] result_reg;
  reg  [15:0] low_reg;
  reg  [15:0] high_reg;
  reg  [2:0] stat_reg;
  reg  [2:0] mask_reg;
  reg  [31:0] meas_reg;
  reg        intr_reg;
  reg  [31:0] rdata_next;
  reg        above_next;
  reg        below_next;
  wire       wr_ctrl;
  wire       rd_ctrl;
  wire       wr_any;
  wire       rd_take;
  wire       done_clr;
  wire [15:0] ctrl_word;
  wire [15:0] result_view;
  wire [26:0] lux_result;
  wire [26:0] lux_low;
  wire [26:0] lux_high;
  wire       over_high;
  wire       under_low;
  wire       q_above;
  wire       q_below;
  wire       active;
  wire       meas_stb;
  wire       int_active;
  wire [2:0] events;

  // reset image of the control word, sliced per field below
  localparam [15:0] CTRL_RST = `CTRL_RESET;

  // reset release through two flip-flops
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // address phase capture
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
    end else if (hready) begin
      ph_valid_reg <= hsel && htrans[1];
      ph_write_reg <= hwrite;
      ph_addr_reg  <= haddr;
    end
  end

  assign wr_any  = ph_valid_reg && ph_write_reg;
  assign wr_ctrl = wr_any && (ph_addr_reg == `OFS_CTRL);
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  // clear lands on the edge that captures the read data
  assign rd_ctrl = rd_take && (haddr == `OFS_CTRL);

  // converted into a common scale: mantissa shifted by exponent
  // wide enough for a full mantissa at the largest exponent
  assign lux_result = {15'h0000, conv_result[11:0]} << conv_result[15:12];
  assign lux_low    = {15'h0000, low_reg[11:0]} << low_reg[15:12];
  assign lux_high   = {15'h0000, high_reg[11:0]} << high_reg[15:12];
  assign over_high  = lux_result > lux_high;
  assign under_low  = lux_result < lux_low;

  assign active   = (mode_reg != `MODE_SHUTDOWN);
  assign meas_stb = conv_done && active;

  fault_qualifier above_q (
    .clk             (clk),
    .rst_sync_b      (rst_sync_reg),
    .meas_stb        (meas_stb),
    .fault           (over_high),
    .fault_count_sel (fc_reg),
    .qualified       (q_above)
  );

  fault_qualifier below_q (
    .clk             (clk),
    .rst_sync_b      (rst_sync_reg),
    .meas_stb        (meas_stb),
    .fault           (under_low),
    .fault_count_sel (fc_reg),
    .qualified       (q_below)
  );

  // limit flag next state
  always @* begin
    above_next = above_reg;
    below_next = below_reg;
    if (latch_reg && rd_ctrl) begin
      above_next = 1'b0;
      below_next = 1'b0;
    end
    if (meas_stb) begin
      if (latch_reg) begin
        if (q_above)
          above_next = 1'b1;
        if (q_below)
          below_next = 1'b1;
      end else begin
        above_next = q_above;
        below_next = q_below;
      end
    end
  end

  assign ctrl_word = {range_reg, ctime_reg, mode_reg, ovf_reg, done_reg, above_reg,
                      below_reg, latch_reg, pol_reg, emask_reg, fc_reg};
  assign result_view = (emask_reg && (range_reg < `RANGE_AUTO)) ?
                       {`EXP_ZERO, result_reg[11:0]} : result_reg;
  assign int_active = above_reg || below_reg;
  assign events = {q_below & meas_stb, q_above & meas_stb, meas_stb};
  assign done_clr = rd_ctrl || (wr_ctrl && (hwdata[`B_MODE_HI:`B_MODE_LO] != `MODE_SHUTDOWN));

  // done flag: set wins over clear
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      done_reg <= CTRL_RST[`B_DONE];
    end else if (meas_stb) begin
      done_reg <= 1'b1;
    end else if (done_clr) begin
      done_reg <= 1'b0;
    end
  end

  // control word fields and captured measurement
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      range_reg  <= CTRL_RST[`B_RANGE_HI:`B_RANGE_LO];
      ctime_reg  <= CTRL_RST[`B_CTIME];
      mode_reg   <= CTRL_RST[`B_MODE_HI:`B_MODE_LO];
      ovf_reg    <= CTRL_RST[`B_OVF];
      above_reg  <= CTRL_RST[`B_ABOVE];
      below_reg  <= CTRL_RST[`B_BELOW];
      latch_reg  <= CTRL_RST[`B_LATCH];
      pol_reg    <= CTRL_RST[`B_POL];
      emask_reg  <= CTRL_RST[`B_EMASK];
      fc_reg     <= CTRL_RST[`B_FC_HI:`B_FC_LO];
      result_reg <= 16'h0000;
      meas_reg   <= 32'h0000_0000;
    end else begin
      above_reg <= above_next;
      below_reg <= below_next;
      if (meas_stb) begin
        result_reg <= conv_result;
        ovf_reg    <= conv_ovf;
        meas_reg   <= meas_reg + 32'h1;
      end
      if (wr_ctrl) begin
        // flag positions are not writable
        range_reg <= hwdata[`B_RANGE_HI:`B_RANGE_LO];
        ctime_reg <= hwdata[`B_CTIME];
        mode_reg  <= hwdata[`B_MODE_HI:`B_MODE_LO];
        latch_reg <= hwdata[`B_LATCH];
        pol_reg   <= hwdata[`B_POL];
        emask_reg <= hwdata[`B_EMASK];
        fc_reg    <= hwdata[`B_FC_HI:`B_FC_LO];
      end else if (meas_stb && mode_reg == `MODE_SINGLE)
        mode_reg <= `MODE_SHUTDOWN;
    end
  end

  // limit registers; a new limit waits for the next conversion
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      low_reg  <= `LOW_RESET;
      high_reg <= `HIGH_RESET;
    end else begin
      if (wr_any && ph_addr_reg == `OFS_LOW_LIM)
        low_reg <= hwdata[15:0];
      if (wr_any && ph_addr_reg == `OFS_HIGH_LIM)
        high_reg <= hwdata[15:0];
    end
  end

  // interrupt status, mask and outputs
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      stat_reg    <= 3'h0;
      mask_reg    <= 3'h0;
      irq         <= 1'b0;
      int_pin_out <= 1'b0;
      int_pin_oe  <= 1'b0;
      conv_mode   <= `MODE_SHUTDOWN;
    end else begin
      if (wr_any && ph_addr_reg == `OFS_IRQ_STAT)
        stat_reg <= (stat_reg & ~hwdata[2:0]) | events;
      else
        stat_reg <= stat_reg | events;
      if (wr_any && ph_addr_reg == `OFS_IRQ_MASK)
        mask_reg <= hwdata[2:0];
      irq         <= |(stat_reg & mask_reg);
      int_pin_out <= 1'b0;
      // polarity zero: drive low while active; one: drive low while idle
      if (pol_reg)
        int_pin_oe <= !(above_next || below_next);
      else
        int_pin_oe <= above_next || below_next;
      conv_mode   <= mode_reg;
    end
  end

  // read mux
  always @* begin
    case (haddr)
      `OFS_CTRL:     rdata_next = {16'h0000, ctrl_word};
      `OFS_RESULT:   rdata_next = {16'h0000, result_view};
      `OFS_LOW_LIM:  rdata_next = {16'h0000, low_reg};
      `OFS_HIGH_LIM: rdata_next = {16'h0000, high_reg};
      `OFS_IRQ_STAT: rdata_next = {29'h0, stat_reg};
      `OFS_IRQ_MASK: rdata_next = {29'h0, mask_reg};
      `OFS_MEAS:     rdata_next = meas_reg;
      `OFS_ID:       rdata_next = {16'h0000, `ID_VALUE};
      default:       rdata_next = 32'h0000_0000;
    endcase
  end

  // zero-wait bus outputs; read data captured at the address phase,
  // so a control read returns the flags as they stood before its clear
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= rd_take ? rdata_next : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  wire unused_ok = &{hsize, int_active, intr_reg, 1'b1};
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg)
      intr_reg <= 1'b0;
    else
      intr_reg <= int_active;
  end
endmodule

// File: src/light_irq_defines.vh
// constants for the light threshold flag and interrupt block
`ifndef LIGHT_IRQ_DEFINES_VH
`define LIGHT_IRQ_DEFINES_VH
// register byte offsets
`define OFS_CTRL       8'h00
`define OFS_RESULT     8'h04
`define OFS_LOW_LIM    8'h08
`define OFS_HIGH_LIM   8'h0c
`define OFS_IRQ_STAT   8'h10
`define OFS_IRQ_MASK   8'h14
`define OFS_MEAS       8'h18
`define OFS_ID         8'h1c
// control word field positions
`define B_RANGE_HI     15
`define B_RANGE_LO     12
`define B_CTIME        11
`define B_MODE_HI      10
`define B_MODE_LO      9
`define B_OVF          8
`define B_DONE         7
`define B_ABOVE        6
`define B_BELOW        5
`define B_LATCH        4
`define B_POL          3
`define B_EMASK        2
`define B_FC_HI        1
`define B_FC_LO        0
// reset values
`define CTRL_RESET     16'hc810
`define LOW_RESET      16'hc000
`define HIGH_RESET     16'hbfff
`define ID_VALUE       16'h5a5a // arbitrary identification value
// mode, range and exponent codes
`define MODE_SHUTDOWN  2'h0
`define MODE_SINGLE    2'h1
`define RANGE_AUTO     4'hc
`define EXP_ZERO       4'h0
// interrupt status bits
`define IRQ_DONE       0
`define IRQ_ABOVE      1
`define IRQ_BELOW      2
`endif

// File: src/fault_qualifier.v
// consecutive fault counter for one limit comparison
`timescale 1ns/1ps
`include "light_irq_defines.vh"
module fault_qualifier (
  // clock and reset
  input  wire       clk,
  input  wire       rst_sync_b,
  // measurement strobe and comparison
  input  wire       meas_stb,
  input  wire       fault,
  input  wire [1:0] fault_count_sel,
  // qualified fault, valid with meas_stb
  output wire       qualified
);
  reg  [3:0] count_reg;
  reg  [3:0] count_next;
  wire [3:0] need;

  assign need = (4'h1 << fault_count_sel);
  assign qualified = fault && ((count_reg + 4'h1) >= need);

  always @* begin
    count_next = count_reg;
    if (meas_stb) begin
      if (!fault)
        count_next = 4'h0;
      else if (count_reg < 4'h8)
        count_next = count_reg + 4'h1;
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b)
      count_reg <= 4'h0;
    else
      count_reg <= count_next;
  end
endmodule

// File: test/light_threshold_irq_flags_properties.sv
// assertion checker for the light threshold flag block
`timescale 1ns/1ps
module light_irq_checker (
  // clock, reset and bus
  input wire logic        clk, rst_b, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans, conv_mode,
  input wire logic [31:0] hrdata,
  // conversion and interrupt
  input wire logic        conv_done, int_pin_out, int_pin_oe, irq
);
  logic [2:0] since;
  logic       rd_dp;
  logic [7:0] a_dp;
  logic       wr_dp;
  logic       clean;
  wire        taken = hsel & htrans[1] & hready;
  // cycles since the last transfer or conversion, saturating
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since <= 3'h7;
      rd_dp <= 1'b0;
      a_dp <= 8'h00;
      wr_dp <= 1'b0;
      clean <= 1'b0;
    end else begin
      since <= (taken | conv_done) ? 3'h0 : ((since == 3'h7) ? since : since + 3'h1);
      rd_dp <= taken & ~hwrite;
      a_dp <= haddr;
      wr_dp <= taken & hwrite;
      // a control read with no write or conversion since
      if (conv_done | (taken & hwrite))
        clean <= 1'b0;
      else if (taken & ~wr_dp & (haddr == 8'h00))
        clean <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_pin_low_only: assert property (int_pin_out == 1'b0 && hreadyout && !hresp)
    else $error("interrupt pin driven high or bus not okay");
  chk_pin_cause: assert property ($changed(int_pin_oe) |-> since < 3'h4)
    else $error("interrupt pin moved with no cause");
  chk_irq_cause: assert property ($changed(irq) |-> since < 3'h4)
    else $error("irq moved with no cause");
  chk_mode_cause: assert property ($changed(conv_mode) |-> since < 3'h4)
    else $error("mode moved with no cause");
  chk_single_back: assert property (conv_mode == 2'h1 && conv_done && since >= 3'h2
    |-> ##2 conv_mode == 2'h0) else $error("single conversion did not return to shutdown");
  chk_shutdown_hold: assert property (conv_mode == 2'h0 && conv_done && !taken
    && since >= 3'h2 |-> ##1 $stable(int_pin_oe) ##1 $stable(irq))
    else $error("conversion in shutdown changed the pin");
  chk_read_clears: assert property (rd_dp && a_dp == 8'h00 && $past(clean)
    |-> !hrdata[7] && (!hrdata[4] || hrdata[6:5] == 2'h0))
    else $error("second control read still shows flags");
  chk_unmapped_zero: assert property (rd_dp && a_dp >= 8'h20 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (conv_done && conv_mode == 2'h1);
  cover property ($rose(irq));
  cover property (rd_dp && a_dp == 8'h00 && hrdata[6:5] != 2'h0);
endmodule
bind light_threshold_irq_flags light_irq_checker u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr),
  .htrans(htrans), .conv_mode(conv_mode), .hrdata(hrdata), .conv_done(conv_done),
  .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .irq(irq));

// File: test/light_host_model.sv
// host model: ahb-lite master and pulled-up interrupt line
`timescale 1ns/1ps
module light_host_model (
  // clock and bus
  input  wire logic        clk, hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel, hwrite,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // interrupt pin
  input  wire logic        int_pin_out, int_pin_oe,
  output wire logic        int_line
);
  // pull-up holds the line high when released
  assign int_line = int_pin_oe ? int_pin_out : 1'b1;
  initial begin
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // a control read is also the latched clearing event
  task automatic xfer(input logic w, input logic [7:0] a, input int d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

// File: test/light_threshold_irq_flags_tb.sv
// self-checking bench for the light threshold flag block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module light_threshold_irq_flags_tb;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, conv_done, conv_ovf;
  logic int_pin_out, int_pin_oe, irq, int_line;
  logic [7:0] haddr;
  logic [1:0] htrans, conv_mode;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [15:0] conv_result;
  int bad_count, num_checks, cyc, m, fd, fa, fb, ov, ch, cl, st, mk, res, i, r, d;
  int lo = 'h200;
  int hi = 'h1400;
  light_threshold_irq_flags DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
    .conv_result(conv_result), .conv_ovf(conv_ovf), .conv_mode(conv_mode),
    .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .irq(irq));
  light_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .hwrite(hwrite), .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwdata(hwdata),
    .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .int_line(int_line));
  function automatic int lux(int v);
    return (v & 'hfff) << ((v >> 12) & 15);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // let pin and irq settle, compare, then realign to an edge
  task automatic chk_all;
    repeat (2) @(posedge clk);
    #1;
    `CHK(int_line, 1'(!((fa | fb) ^ ((m >> 3) & 1))))
    `CHK(irq, 1'(st & mk))
    `CHK(conv_mode, 2'((m >> 9) & 3))
    @(posedge clk);
  endtask
  task automatic conv(input int v, input int o);
    conv_done <= 1'b1;
    conv_result <= v[15:0];
    conv_ovf <= o[0];
    @(posedge clk);
    conv_done <= 1'b0;
    if (((m >> 9) & 3) != 0) begin
      fd = 1;
      ov = o;
      res = v;
      st = 1;
      ch = (lux(v) > lux(hi)) ? ((ch < 8) ? ch + 1 : 8) : 0;
      cl = (lux(v) < lux(lo)) ? ((cl < 8) ? cl + 1 : 8) : 0;
      r = 1 << (m & 3);
      fa = (m & 'h10) ? (fa | (ch >= r)) : (ch >= r);
      fb = (m & 'h10) ? (fb | (cl >= r)) : (cl >= r);
      if (((m >> 9) & 3) == 1) m = m & ~'h600;
    end
    chk_all;
  endtask
  task automatic wr_ctrl(input int v);
    host.xfer(1'b1, 8'h00, v, q);
    m = v & 'hfe1f;
    if (((m >> 9) & 3) != 0) fd = 0;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    rst_b = 1'b0;
    conv_done = 1'b0;
    conv_ovf = 1'b0;
    conv_result = 16'h0000;
    m = 'hc810;
    res = -1;
    void'($urandom(32'h0215));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    host.xfer(1'b0, 8'h00, 0, q);
    `CHK(q, 32'h0000c810)
    host.xfer(1'b1, 8'h08, lo, q);
    host.xfer(1'b1, 8'h0c, hi, q);
    host.xfer(1'b1, 8'h40, 'hffff, q);
    host.xfer(1'b0, 8'h40, 0, q);
    `CHK(q, 32'h0)
    for (i = 0; i < 400; i++) begin
      if (i == 200) begin
        wr_ctrl('h0400);
        conv($urandom & 'h3fff, 0);
      end
      r = $urandom;
      case (r % 6)
        0: begin
          d = ($urandom & 'hffef) | ((i < 200) ? 'h10 : 0);
          wr_ctrl(d);
        end
        1, 2: conv($urandom & 'h3fff, (r >> 4) & 1);
        3: begin
          host.xfer(1'b0, 8'h00, 0, q);
          `CHK(q, 32'(m | (ov << 8) | (fd << 7) | (fa << 6) | (fb << 5)))
          fd = 0;
          if (m & 'h10) begin
            fa = 0;
            fb = 0;
          end
        end
        4: if (res >= 0) begin
          host.xfer(1'b0, 8'h04, 0, q);
          `CHK(q, 32'(((m & 4) && ((m >> 12) & 15) < 12) ? (res & 'hfff) : res))
        end
        default: begin
          host.xfer(1'b0, 8'h10, 0, q);
          `CHK(q[0], 1'(st))
          mk = (r >> 8) & 1;
          host.xfer(1'b1, 8'h14, mk, q);
          if (r & 'h200) begin
            host.xfer(1'b1, 8'h10, 7, q);
            st = 0;
          end
        end
      endcase
      chk_all;
    end
    tally_and_finish;
  end
endmodule
